// ### ppm_map.svh
// register offsets, field positions, reset values and write mask for the port mode block
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
`define PPM_MODE_OFS 4'h0
`define PPM_ADDR_OFS 4'h4
`define PPM_CTRL_OFS 4'h8
`define PPM_DOUT_OFS 4'hc
`define PPM_BUSY_BIT 15
`define PPM_INTERRUPT_REQUEST_POLICY_HI 14
`define PPM_INTERRUPT_REQUEST_POLICY_LO 13
`define PPM_ADDRESS_STEP_POLICY_HI 12
`define PPM_ADDRESS_STEP_POLICY_LO 11
`define PPM_MODE_HI 9
`define PPM_MODE_LO 8
`define PPM_SETUP_WAIT_COUNT_HI 7
`define PPM_SETUP_WAIT_COUNT_LO 6
`define PPM_STROBE_WAIT_COUNT_HI 5
`define PPM_STROBE_WAIT_COUNT_LO 2
`define PPM_END_WAIT_COUNT_HI 1
`define PPM_END_WAIT_COUNT_LO 0
`define PPM_MODE_RST 16'h0000
`define PPM_MODE_WMASK 16'h7bff
`define PPM_CTRL_RST 2'h0
`endif

// ### ppm_pkg.sv
// types shared by the port mode block
package ppm_pkg;
   typedef enum logic [1:0] {
      PPM_LEGACY_SLAVE = 2'b00,
      PPM_ENH_SLAVE = 2'b01,
      PPM_MASTER2 = 2'b10,
      PPM_MASTER1 = 2'b11
   } ppm_mode_e;
   typedef enum logic [1:0] {
      PPM_IRQ_NONE = 2'b00,
      PPM_IRQ_CYCLE = 2'b01,
      PPM_IRQ_BUF3 = 2'b10,
      PPM_IRQ_RSVD = 2'b11
   } ppm_irq_e;
   typedef enum logic [1:0] {
      PPM_STEP_NONE = 2'b00,
      PPM_STEP_INC = 2'b01,
      PPM_STEP_DEC = 2'b10,
      PPM_STEP_BUF = 2'b11
   } ppm_step_e;
   typedef enum logic [2:0] {
      PPM_ST_IDLE = 3'b000,
      PPM_ST_SETUP = 3'b001,
      PPM_ST_STROBE = 3'b010,
      PPM_ST_END = 3'b011,
      PPM_ST_DONE = 3'b100
   } ppm_state_e;
endpackage

// ### ppm_sync.sv
// two-flop synchroniser for a bundle of pin inputs
module ppm_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// ### ppm_addr_step.sv
// address stepper: bits 10..2 and bit 14 count as one 10-bit value; bits 10..2 alone when bit 14 is chip select
module ppm_addr_step (
   input wire logic [15:0] addr_i,
   input wire ppm_pkg::ppm_step_e step_i,
   input wire logic cs_on_a14_i,
   output logic [15:0] addr_o
);
   import ppm_pkg::*;
   logic [9:0] cnt;
   logic [9:0] nxt;
   always_comb begin
      cnt = cs_on_a14_i ? {1'b0, addr_i[10:2]} : {addr_i[14], addr_i[10:2]};
      case (step_i)
         PPM_STEP_INC: nxt = cnt + 10'h001;
         PPM_STEP_DEC: nxt = cnt - 10'h001;
         default: nxt = cnt;
      endcase
      addr_o = addr_i;
      addr_o[10:2] = nxt[8:0];
      if (!cs_on_a14_i) begin
         addr_o[14] = nxt[9];
      end
   end
endmodule

// ### ppm_top.sv
// parallel port mode control: register file, master strobe sequencer and slave buffers
//
// Function
// - busy reads 1 during a master transfer, 0 otherwise
// - interrupt policy 01 pulses at every cycle end; 00 never
// - policy 10 pulses on buffer 3 access or address 11 access
// - step policy 01 increments address bits 10..2 and 14
// - step policy 10 decrements address bits 10..2 and 14
// - step policy 00 leaves the address alone
// - step policy 11 in legacy slave steps the buffer index
// - bit 14 used as chip select is never stepped
// - mode 11 drives select, direction, enable, address, data
// - mode 10 drives select, separate read and write strobes
// - mode 01 enhanced slave with two address inputs
// - mode 00 legacy slave without address inputs
// - setup phase lasts setup wait count plus one clocks
// - strobe lasts strobe wait count plus one clocks
// - strobe count zero forces one setup and one end clock on writes
// - strobe count zero gives one setup, zero end clocks on reads
// - mode bit 10 and bits 31..16 read zero
//
// Local design decisions: the register addresses and the address-and-strobe port.
`include "ppm_map.svh"
module ppm_top (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic IRQ_O,
   output logic CS_O,
   output logic RD_STB_O,
   output logic WR_STB_O,
   output logic DIR_O,
   output logic EN_STB_O,
   output logic [15:0] PA_O,
   output logic [7:0] PD_O,
   output logic PD_OE_O,
   input wire logic [7:0] PD_I,
   input wire logic S_CS_I,
   input wire logic S_RD_I,
   input wire logic S_WR_I,
   input wire logic [1:0] S_A_I
);
   import ppm_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] mode_q;
   logic [15:0] addr_q;
   logic [15:0] addr_d;
   logic [1:0] ctrl_q;
   logic [7:0] dout_q;
   logic [7:0] din_q;
   ppm_state_e st_q;
   logic [3:0] cnt_q;
   logic busy_q;
   logic is_rd_q;
   logic irq_q;
   logic [7:0] wbuf_q [4];
   logic [7:0] rbuf_q [4];
   logic [1:0] bidx_q;
   logic [2:0] s_ctl;
   logic [1:0] s_a;
   logic [7:0] s_d;
   logic s_rd_d1_q;
   logic s_wr_d1_q;
   logic s_rd_fall;
   logic s_wr_fall;
   logic [1:0] s_idx;
   logic [15:0] mode_rd;
   ppm_mode_e mode;
   ppm_irq_e interrupt_request_policy;
   ppm_step_e address_step_policy;
   logic is_master;
   logic start_rd;
   logic start_wr;
   logic [1:0] wb;
   logic [3:0] wm;
   logic [1:0] we;
   logic cycle_end;
   logic [2:0] cap_q;

   function automatic logic sel(input logic [3:0] a, input logic [3:0] ofs);
      sel = (a == ofs);
   endfunction

   assign mode = ppm_mode_e'(mode_q[`PPM_MODE_HI:`PPM_MODE_LO]);
   assign interrupt_request_policy = ppm_irq_e'(mode_q[`PPM_INTERRUPT_REQUEST_POLICY_HI:`PPM_INTERRUPT_REQUEST_POLICY_LO]);
   assign address_step_policy = ppm_step_e'(mode_q[`PPM_ADDRESS_STEP_POLICY_HI:`PPM_ADDRESS_STEP_POLICY_LO]);
   assign wb = mode_q[`PPM_SETUP_WAIT_COUNT_HI:`PPM_SETUP_WAIT_COUNT_LO];
   assign wm = mode_q[`PPM_STROBE_WAIT_COUNT_HI:`PPM_STROBE_WAIT_COUNT_LO];
   assign we = mode_q[`PPM_END_WAIT_COUNT_HI:`PPM_END_WAIT_COUNT_LO];
   assign is_master = mode_q[`PPM_MODE_HI];
   // a transfer request is only honoured while idle in a master mode
   assign start_wr = WR_I && sel(ADDR_I, `PPM_DOUT_OFS) && is_master && !busy_q;
   assign start_rd = WR_I && sel(ADDR_I, `PPM_CTRL_OFS) && WDATA_I[0] && is_master && !busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // pins from the external host cross into this clock before use
   ppm_sync #(.W(13)) u_sync (
      .clk_i(MCLK_I),
      .rstn_i(RSTN_I),
      .d_i({S_CS_I, S_RD_I, S_WR_I, S_A_I, PD_I}),
      .q_o({s_ctl, s_a, s_d})
   );

   ppm_addr_step u_step (
      .addr_i(addr_q),
      .step_i(address_step_policy),
      .cs_on_a14_i(ctrl_q[1]),
      .addr_o(addr_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         mode_q <= `PPM_MODE_RST;
      end else if (WR_I && sel(ADDR_I, `PPM_MODE_OFS)) begin
         mode_q <= WDATA_I[15:0] & `PPM_MODE_WMASK;
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctrl_q <= `PPM_CTRL_RST;
      end else if (WR_I && sel(ADDR_I, `PPM_CTRL_OFS)) begin
         ctrl_q <= {WDATA_I[1], 1'b0};
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         dout_q <= 8'h00;
      end else if (start_wr) begin
         dout_q <= WDATA_I[7:0];
      end
   end

   // address steps after each master cycle; a software write in the same cycle wins
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         addr_q <= 16'h0000;
      end else if (WR_I && sel(ADDR_I, `PPM_ADDR_OFS)) begin
         addr_q <= WDATA_I[15:0];
      end else if (cycle_end) begin
         addr_q <= addr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master sequencer: setup, strobe, end hold, done
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st_q <= PPM_ST_IDLE;
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         is_rd_q <= 1'b0;
      end else begin
         case (st_q)
            PPM_ST_IDLE: begin
               if (start_wr || start_rd) begin
                  st_q <= PPM_ST_SETUP;
                  busy_q <= 1'b1;
                  is_rd_q <= start_rd;
                  cnt_q <= (wm == 4'h0) ? 4'h0 : {2'b00, wb};
               end
            end
            PPM_ST_SETUP: begin
               if (cnt_q == 4'h0) begin
                  st_q <= PPM_ST_STROBE;
                  cnt_q <= wm;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            PPM_ST_STROBE: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else if (wm == 4'h0 && is_rd_q) begin
                  st_q <= PPM_ST_DONE;
               end else begin
                  st_q <= PPM_ST_END;
                  cnt_q <= (wm == 4'h0) ? 4'h0 : {2'b00, we};
               end
            end
            PPM_ST_END: begin
               if (cnt_q == 4'h0) begin
                  st_q <= PPM_ST_DONE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            PPM_ST_DONE: begin
               if (cycle_end) begin
                  st_q <= PPM_ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
            default: begin
               st_q <= PPM_ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // data pins arrive three clocks late (pin flop plus two sync flops), so capture is
   // delayed to match; done waits for it, so busy never clears before the byte lands
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cap_q <= 3'h0;
      end else begin
         cap_q <= {cap_q[1:0], st_q == PPM_ST_STROBE && cnt_q == 4'h0 && is_rd_q};
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         din_q <= 8'h00;
      end else if (cap_q[2]) begin
         din_q <= s_d;
      end
   end

   assign cycle_end = (st_q == PPM_ST_DONE) && (cap_q[1:0] == 2'b00);

   // master pins; in master mode 1 the enable carries the strobe and direction the sense
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         CS_O <= 1'b0;
         RD_STB_O <= 1'b0;
         WR_STB_O <= 1'b0;
         DIR_O <= 1'b0;
         EN_STB_O <= 1'b0;
         PA_O <= 16'h0000;
         PD_O <= 8'h00;
         PD_OE_O <= 1'b0;
      end else begin
         CS_O <= busy_q && is_master;
         PA_O <= addr_q;
         PD_O <= is_master ? dout_q : rbuf_q[s_idx];
         EN_STB_O <= (mode == PPM_MASTER1) && st_q == PPM_ST_STROBE;
         DIR_O <= (mode == PPM_MASTER1) && is_rd_q && busy_q;
         RD_STB_O <= (mode == PPM_MASTER2) && st_q == PPM_ST_STROBE && is_rd_q;
         WR_STB_O <= (mode == PPM_MASTER2) && st_q == PPM_ST_STROBE && !is_rd_q;
         // write data stands through setup, strobe and end hold
         PD_OE_O <= is_master ? (busy_q && !is_rd_q && st_q != PPM_ST_DONE)
                              : (s_ctl[2] && s_ctl[1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave side: legacy uses a stepping buffer index, enhanced uses the address pins
   assign s_idx = (mode == PPM_ENH_SLAVE) ? s_a : bidx_q;
   assign s_rd_fall = s_rd_d1_q && !s_ctl[1];
   assign s_wr_fall = s_wr_d1_q && !s_ctl[0];

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s_rd_d1_q <= 1'b0;
         s_wr_d1_q <= 1'b0;
      end else begin
         s_rd_d1_q <= s_ctl[1] && s_ctl[2] && !is_master;
         s_wr_d1_q <= s_ctl[0] && s_ctl[2] && !is_master;
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_buf
      always_ff @(posedge MCLK_I or negedge RSTN_I) begin
         if (!RSTN_I) begin
            wbuf_q[i] <= 8'h00;
            rbuf_q[i] <= 8'h00;
         end else begin
            if (s_ctl[0] && s_ctl[2] && !is_master && s_idx == 2'(i)) begin
               wbuf_q[i] <= s_d;
            end
            if (WR_I && sel(ADDR_I, 4'(i)) && !is_master && i != 0) begin
               rbuf_q[i] <= WDATA_I[7:0];
            end
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         bidx_q <= 2'h0;
      end else if (mode != PPM_LEGACY_SLAVE || address_step_policy != PPM_STEP_BUF) begin
         bidx_q <= 2'h0;
      end else if (s_rd_fall || s_wr_fall) begin
         bidx_q <= bidx_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-cycle interrupt pulse; policy 11 is left to software to avoid
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         irq_q <= 1'b0;
      end else begin
         case (interrupt_request_policy)
            PPM_IRQ_CYCLE: irq_q <= cycle_end || s_rd_fall || s_wr_fall;
            PPM_IRQ_BUF3: irq_q <= (s_rd_fall || s_wr_fall) && s_idx == 2'h3;
            default: irq_q <= 1'b0;
         endcase
      end
   end
   assign IRQ_O = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mode_rd = mode_q;
      mode_rd[`PPM_BUSY_BIT] = busy_q && is_master;
   end

   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         RDATA_O <= 32'h0000_0000;
      end else if (RD_I) begin
         case (ADDR_I)
            `PPM_MODE_OFS: RDATA_O <= {16'h0000, mode_rd};
            `PPM_ADDR_OFS: RDATA_O <= {16'h0000, addr_q};
            `PPM_CTRL_OFS: RDATA_O <= {30'h0, ctrl_q[1], busy_q};
            `PPM_DOUT_OFS: RDATA_O <= {24'h0, is_master ? din_q : wbuf_q[3]};
            4'h1: RDATA_O <= {24'h0, wbuf_q[0]};
            4'h2: RDATA_O <= {24'h0, wbuf_q[1]};
            4'h3: RDATA_O <= {24'h0, wbuf_q[2]};
            default: RDATA_O <= 32'h0000_0000;
         endcase
      end else begin
         RDATA_O <= 32'h0000_0000;
      end
   end
endmodule

// ### ppm_top_assertions.sv
// pin-level assertions for the port mode block
`include "ppm_map.svh"
////////////////////////////////////////////////////////////
module ppm_chk (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic IRQ_O,
   input wire logic CS_O,
   input wire logic RD_STB_O,
   input wire logic WR_STB_O,
   input wire logic EN_STB_O
);
   logic stb;
   logic [1:0] interrupt_request_policy_q;
   logic [1:0] setup_wait_count_q;
   logic [3:0] strobe_wait_count_q;
   logic [4:0] len_q;
   logic [2:0] pre_q;
   logic [2:0] pre_exp;
   assign stb = RD_STB_O | WR_STB_O | EN_STB_O;
   // a zero strobe count overrides the setup count
   assign pre_exp = (strobe_wait_count_q == 4'h0) ? 3'h1 : {1'b0, setup_wait_count_q} + 3'h1;
   // shadow of the mode fields, snooped from the register bus
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         interrupt_request_policy_q <= 2'h0;
         setup_wait_count_q <= 2'h0;
         strobe_wait_count_q <= 4'h0;
      end else if (WR_I && ADDR_I == `PPM_MODE_OFS) begin
         interrupt_request_policy_q <= WDATA_I[14:13];
         setup_wait_count_q <= WDATA_I[7:6];
         strobe_wait_count_q <= WDATA_I[5:2];
      end
   end
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         len_q <= 5'h0;
         pre_q <= 3'h0;
      end else begin
         len_q <= stb ? len_q + 5'h1 : 5'h0;
         pre_q <= !CS_O ? 3'h0 : (stb ? pre_q : pre_q + 3'h1);
      end
   end
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_setup; $rose(stb) |-> pre_q == pre_exp; endproperty
   property p_len; (!stb && len_q != 5'h0) |-> len_q == {1'b0, strobe_wait_count_q} + 5'h1; endproperty
   property p_cs; stb |-> CS_O; endproperty
   property p_excl; !(RD_STB_O && WR_STB_O); endproperty
   property p_en; EN_STB_O |-> !RD_STB_O && !WR_STB_O; endproperty
   property p_irq_none; interrupt_request_policy_q == 2'h0 && $past(interrupt_request_policy_q) == 2'h0 |-> !IRQ_O; endproperty
   property p_irq_end; $fell(stb) && interrupt_request_policy_q == 2'h1 |-> ##[0:40] IRQ_O; endproperty
   property p_rsvd;
      $past(RD_I) && $past(ADDR_I) == `PPM_MODE_OFS |-> RDATA_O[31:16] == 16'h0 && !RDATA_O[10];
   endproperty
   a_setup: assert property (p_setup) else $error("setup length wrong");
   a_len: assert property (p_len) else $error("strobe length wrong");
   a_cs: assert property (p_cs) else $error("strobe without select");
   a_excl: assert property (p_excl) else $error("read and write strobes together");
   a_en: assert property (p_en) else $error("enable strobe with split strobes");
   a_irq_none: assert property (p_irq_none) else $error("interrupt while off");
   a_irq_end: assert property (p_irq_end) else $error("no interrupt after cycle");
   a_rsvd: assert property (p_rsvd) else $error("unimplemented mode bits set");
   c_long: cover property (stb && len_q == 5'h2);
   c_irq: cover property (IRQ_O);
   c_en: cover property (EN_STB_O);
endmodule
////////////////////////////////////////////////////////////
bind ppm_top ppm_chk ppm_chk_inst (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
   .CS_O(CS_O), .RD_STB_O(RD_STB_O), .WR_STB_O(WR_STB_O), .EN_STB_O(EN_STB_O));

// ### ppm_peer.sv
// far-side model: peripheral for master modes, host for slave modes
module ppm_peer (
   input wire logic clk_i,
   input wire logic cs_i,
   input wire logic rd_stb_i,
   input wire logic wr_stb_i,
   input wire logic dir_i,
   input wire logic en_stb_i,
   input wire logic [15:0] pa_i,
   input wire logic [7:0] dev_d_i,
   input wire logic oe_i,
   output logic [7:0] bus_o,
   output logic [7:0] wb_o,
   output logic s_cs_o,
   output logic s_rd_o,
   output logic s_wr_o,
   output logic [1:0] s_a_o
);
   logic rd;
   logic rsel_q;
   logic hen_q;
   logic [7:0] hd_q;
   logic [7:0] pd_q;
   initial begin
      rsel_q = 1'b0;
      hen_q = 1'b0;
      pd_q = 8'h00;
      s_cs_o = 1'b0;
      s_rd_o = 1'b0;
      s_wr_o = 1'b0;
      s_a_o = 2'h0;
   end
   assign rd = rd_stb_i | (en_stb_i & dir_i);
   // released bus toggles every cycle so a stale byte never looks valid
   assign bus_o = oe_i ? dev_d_i : hen_q ? hd_q : (rsel_q | rd) ? pa_i[7:0] ^ 8'h3c : ~pd_q;
   always @(posedge clk_i) begin
      pd_q <= bus_o;
      rsel_q <= cs_i & (rd | rsel_q);
      if (wr_stb_i | (en_stb_i & !dir_i)) wb_o <= bus_o;
   end
   // host write: strobe held long enough to pass the input synchroniser
   task host_wr(input logic [1:0] a, input logic [7:0] d);
      s_cs_o <= 1'b1;
      s_a_o <= a;
      hd_q <= d;
      hen_q <= 1'b1;
      @(posedge clk_i) s_wr_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      s_wr_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      s_cs_o <= 1'b0;
      hen_q <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
   // host read: enable and byte taken while the strobe still stands past the synchroniser
   task host_rd(input logic [1:0] a, output logic [8:0] d);
      s_cs_o <= 1'b1;
      s_a_o <= a;
      @(posedge clk_i) s_rd_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      d = {oe_i, dev_d_i};
      s_rd_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      s_cs_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// ### ppm_top_tb.sv
// self-checking bench for the port mode block
`include "ppm_map.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
////////////////////////////////////////////////////////////
module ppm_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, wr, rd, irq, cs, rds, wrs, dir, ens, oe, scs, srd, swr;
   logic [3:0] adr;
   logic [31:0] wd, rdata, v;
   logic [15:0] pa;
   logic [7:0] pdo, pdi, wb;
   logic [1:0] sa;
   logic [8:0] pb;
   int num_errors = 0;
   int tests_run = 0;
   int irqs = 0;
   int n;
   logic [15:0] a0_t [6] = '{16'h0004, 16'h0008, 16'h0010, 16'h07fc, 16'h47fc, 16'h4000};
   logic [15:0] ae_t [6] = '{16'h0008, 16'h0004, 16'h0010, 16'h4000, 16'h4000, 16'h07fc};
   logic [1:0] inc_t [6] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
   logic [1:0] ctl_t [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
   ppm_top ppm_top_inst (.MCLK_I(clk), .RSTN_I(rstn), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .CS_O(cs), .RD_STB_O(rds), .WR_STB_O(wrs),
      .DIR_O(dir), .EN_STB_O(ens), .PA_O(pa), .PD_O(pdo), .PD_OE_O(oe), .PD_I(pdi),
      .S_CS_I(scs), .S_RD_I(srd), .S_WR_I(swr), .S_A_I(sa));
   ppm_peer ppm_peer_inst (.clk_i(clk), .cs_i(cs), .rd_stb_i(rds), .wr_stb_i(wrs), .dir_i(dir),
      .en_stb_i(ens), .pa_i(pa), .dev_d_i(pdo), .oe_i(oe), .bus_o(pdi), .wb_o(wb),
      .s_cs_o(scs), .s_rd_o(srd), .s_wr_o(swr), .s_a_o(sa));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
   task results();
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a gap cycle after each write keeps the strobe from being re-driven in one step
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd_reg(input logic [3:0] a, output logic [31:0] q);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) q = rdata;
      @(posedge clk);
   endtask
   task wait_idle();
      rd_reg(`PPM_MODE_OFS, v);
      `CHK("busy set", 1'b1, v[15])
      for (int k = 0; k < 50 && v[15] !== 1'b0; k++) rd_reg(`PPM_MODE_OFS, v);
      if (v[15] !== 1'b0) begin
         num_errors++;
         results();
      end
   endtask
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd_reg(`PPM_MODE_OFS, v);
      `CHK("mode reset", 32'h0, v)
      wr_reg(`PPM_MODE_OFS, 32'hffffdfff); // interrupt code kept off 11
      rd_reg(`PPM_MODE_OFS, v);
      `CHK("mode bits", 32'h00005bff, v)
      for (int i = 0; i < 6; i++) begin
         wr_reg(`PPM_MODE_OFS, {17'h0, (i == 2) ? 2'h0 : 2'h1, inc_t[i], 1'b0,
            i[0] ? 2'h3 : 2'h2, 2'h3 - i[1:0], 4'(i % 3), i[1:0]});
         wr_reg(`PPM_ADDR_OFS, {16'h0, a0_t[i]});
         wr_reg(`PPM_CTRL_OFS, {30'h0, ctl_t[i]});
         n = irqs;
         if (i[1]) wr_reg(`PPM_CTRL_OFS, {30'h0, ctl_t[i] | 2'h1});
         else wr_reg(`PPM_DOUT_OFS, {24'h0, 8'hc0 + 8'(i)});
         wait_idle();
         rd_reg(`PPM_ADDR_OFS, v);
         `CHK("address", {16'h0, ae_t[i]}, v)
         `CHK("irq count", (i == 2) ? 0 : 1, irqs - n)
         if (i[1]) begin
            rd_reg(`PPM_DOUT_OFS, v);
            `CHK("read byte", {24'h0, a0_t[i][7:0] ^ 8'h3c}, v)
         end else `CHK("write byte", 8'hc0 + 8'(i), wb)
      end
      for (int m = 0; m < 2; m++) begin
         wr_reg(`PPM_MODE_OFS, (m == 1) ? 32'h4100 : 32'h5800);
         for (int a = 0; a < 4; a++) begin
            n = irqs;
            ppm_peer_inst.host_wr((m == 1) ? 2'(a) : 2'h0, 8'h20 + 8'(a + 4 * m));
            `CHK("slave irq", (a == 3) ? 1 : 0, irqs - n)
         end
         for (int a = 0; a < 4; a++) begin
            rd_reg((a == 3) ? `PPM_DOUT_OFS : 4'(a + 1), v);
            `CHK("slave byte", {24'h0, 8'h20 + 8'(a + 4 * m)}, v)
         end
      end
      for (int a = 1; a < 4; a++) begin
         wr_reg(4'(a), {24'h0, 8'h50 + 8'(a)});
         n = irqs;
         ppm_peer_inst.host_rd(2'(a), pb);
         `CHK("host byte", {1'b1, 8'h50 + 8'(a)}, pb)
         `CHK("host read irq", (a == 3) ? 1 : 0, irqs - n)
      end
      results();
   end
endmodule
